// ===== rtl/link_host_pkg.sv
// Package: constants, types and states for the serial block link host controller
package link_host_pkg;
  // ------------------------------------------------------------
  // Handshake codes
  // ------------------------------------------------------------
  localparam logic [7:0] CODE_REQ  = 8'h05; // Transmission request
  localparam logic [7:0] CODE_RDY  = 8'h04; // Ready to receive
  localparam logic [7:0] CODE_ACK  = 8'h06;
  localparam logic [7:0] CODE_NAK  = 8'h15;
  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_HZ          = 125000000;
  localparam int CHAR_TICK_MS    = 100;  // Character timeout unit, 0.1 s
  localparam int PROTO_TICK_MS   = 1000; // Protocol limit unit, 1 s
  localparam int CHAR_TICK_CYC   = CLK_HZ / 1000 * CHAR_TICK_MS;
  localparam int PROTO_TICK_CYC  = CLK_HZ / 1000 * PROTO_TICK_MS;
  localparam int BAUD_2400       = 2400;
  localparam int BAUD_4800       = 4800;
  localparam int BAUD_9600       = 9600;
  localparam int BIT_CYC_2400    = CLK_HZ / BAUD_2400;
  localparam int BIT_CYC_4800    = CLK_HZ / BAUD_4800;
  localparam int BIT_CYC_9600    = CLK_HZ / BAUD_9600;
  // ------------------------------------------------------------
  // Setting defaults and field limits
  // ------------------------------------------------------------
  localparam logic [7:0] CHAR_TO_DEFAULT  = 8'h05;
  localparam logic [7:0] PROTO_TL_DEFAULT = 8'h0A;
  localparam logic [3:0] RETRY_DEFAULT    = 4'h1;
  localparam logic [3:0] RETRY_MAX        = 4'h8;
  localparam logic [7:0] COUNT_MAX        = 8'hF0;
  localparam logic [3:0] MODULE_ID_MIN    = 4'h1;
  localparam int         BLOCK_EXTRA      = 3;
  localparam int         BUF_DEPTH        = 256;
  // ------------------------------------------------------------
  // Software registers (word index)
  // ------------------------------------------------------------
  localparam logic [3:0] REG_CTRL    = 4'h0; // w: bit0 go; r: status
  localparam logic [3:0] REG_CONFIG  = 4'h1; // baud, role, retry
  localparam logic [3:0] REG_TIMES   = 4'h2; // [7:0] char, [15:8] proto
  localparam logic [3:0] REG_HEADER  = 4'h3; // [7:0] N,[11:8] axis,[15:12] cmd,[19:16] mode
  localparam logic [3:0] REG_TXDATA  = 4'h4; // write appends payload byte
  localparam logic [3:0] REG_RXDATA  = 4'h5; // read pops received byte
  localparam logic [3:0] REG_RXINFO  = 4'h6; // received length
  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } sw_req_type;

  typedef struct packed {
    logic [1:0] baud_sel;
    logic       master;
    logic [3:0] retry_limit;
    logic [7:0] char_timeout;
    logic [7:0] protocol_time_limit;
  } link_cfg_type;

  typedef enum logic [3:0] {
    ST_IDLE, ST_SEND_REQ, ST_WAIT_RDY, ST_SEND_BLK, ST_WAIT_ACK,
    ST_SEND_RDY, ST_WAIT_FIRST, ST_RECV_BLK, ST_SEND_ANS
  } link_state_type;
endpackage : link_host_pkg

// ===== rtl/link_host.sv
// Host controller for the servo driver serial block link
`timescale 1ns/1ps
`default_nettype none
module link_host #(
  parameter int CLK_FREQ   = link_host_pkg::CLK_HZ,
  parameter int CHAR_TICK  = link_host_pkg::CHAR_TICK_CYC,
  parameter int PROTO_TICK = link_host_pkg::PROTO_TICK_CYC
) (
  input  wire logic                      core_clk,
  input  wire logic                      rst,
  input  wire link_host_pkg::sw_req_type sw_req,
  output var  logic [31:0]               sw_rdata,
  input  wire logic                      rxd,
  output var  logic                      txd
);
  import link_host_pkg::*;

  // ------------------------------------------------------------
  // Software registers
  // ------------------------------------------------------------
  link_cfg_type   cfg_reg;
  logic [1:0]     baud_live_reg;
  logic [7:0]     hdr_n_reg;
  logic [3:0]     hdr_axis_reg, hdr_cmd_reg, hdr_mode_reg;
  logic           busy_reg, done_reg, err_reg, rx_new_reg, start_reg;
  logic [31:0]    sw_rdata_reg;
  logic [7:0]     txbuf [BUF_DEPTH];
  logic [7:0]     rxbuf [BUF_DEPTH];
  logic [7:0]     tx_wr_reg, rx_rd_reg, rx_len_reg;
  link_state_type state_reg;

  wire sel_ctrl   = sw_req.addr == REG_CTRL;
  wire sel_config = sw_req.addr == REG_CONFIG;
  wire sel_times  = sw_req.addr == REG_TIMES;
  wire sel_header = sw_req.addr == REG_HEADER;
  wire sel_txdata = sw_req.addr == REG_TXDATA;
  wire sel_rxdata = sw_req.addr == REG_RXDATA;
  wire sel_rxinfo = sw_req.addr == REG_RXINFO;
  wire go_wr      = sw_req.wr && sel_ctrl && sw_req.wdata[0] && !busy_reg;

  // Settings writes clamp out-of-range values
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cfg_reg      <= '{2'h0, 1'b0, RETRY_DEFAULT, CHAR_TO_DEFAULT, PROTO_TL_DEFAULT};
      hdr_n_reg    <= 8'h00;
      hdr_axis_reg <= MODULE_ID_MIN;
      hdr_cmd_reg  <= 4'h0;
      hdr_mode_reg <= 4'h0;
      tx_wr_reg    <= 8'h00;
    end else begin
      if (sw_req.wr && sel_config) begin
        cfg_reg.baud_sel    <= (sw_req.wdata[1:0] > 2'h2) ? 2'h2 : sw_req.wdata[1:0];
        cfg_reg.master      <= sw_req.wdata[2];
        cfg_reg.retry_limit <= (sw_req.wdata[7:4] == 4'h0) ? RETRY_DEFAULT :
                               (sw_req.wdata[7:4] > RETRY_MAX) ? RETRY_MAX : sw_req.wdata[7:4];
      end
      if (sw_req.wr && sel_times) begin
        cfg_reg.char_timeout        <= (sw_req.wdata[7:0] == 8'h00) ? 8'h01 : sw_req.wdata[7:0];
        cfg_reg.protocol_time_limit <= (sw_req.wdata[15:8] == 8'h00) ? 8'h01 : sw_req.wdata[15:8];
      end
      if (sw_req.wr && sel_header) begin
        hdr_n_reg    <= (sw_req.wdata[7:0] > COUNT_MAX) ? COUNT_MAX : sw_req.wdata[7:0];
        hdr_axis_reg <= (sw_req.wdata[11:8] == 4'h0) ? MODULE_ID_MIN : sw_req.wdata[11:8];
        hdr_cmd_reg  <= sw_req.wdata[15:12];
        hdr_mode_reg <= sw_req.wdata[19:16];
        tx_wr_reg    <= 8'h00;
      end else if (sw_req.wr && sel_txdata && !busy_reg) begin
        tx_wr_reg <= tx_wr_reg + 8'h01;
      end
    end
  end

  // Payload store written by software
  always_ff @(posedge core_clk) begin
    if (sw_req.wr && sel_txdata && !busy_reg) begin
      txbuf[tx_wr_reg] <= sw_req.wdata[7:0];
    end
  end

  // Baud choice frozen at reset release only
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      baud_live_reg <= 2'h0;
      start_reg     <= 1'b1;
    end else begin
      start_reg <= 1'b0;
      if (start_reg) begin
        baud_live_reg <= cfg_reg.baud_sel;
      end
    end
  end

  wire [31:0] bit_cyc = (baud_live_reg == 2'h0) ? 32'(CLK_FREQ / BAUD_2400) :
                        (baud_live_reg == 2'h1) ? 32'(CLK_FREQ / BAUD_4800) : 32'(CLK_FREQ / BAUD_9600);

  // ------------------------------------------------------------
  // Serial transmitter and receiver, 8N1
  // ------------------------------------------------------------
  logic [9:0]  tx_shift_reg;
  logic [3:0]  tx_bits_reg;
  logic [31:0] tx_cnt_reg;
  logic        tx_go;
  logic [7:0]  tx_byte;
  wire         tx_idle = tx_bits_reg == 4'h0;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_shift_reg <= 10'h3FF;
      tx_bits_reg  <= 4'h0;
      tx_cnt_reg   <= 32'h0;
    end else if (tx_go && tx_idle) begin
      tx_shift_reg <= {1'b1, tx_byte, 1'b0};
      tx_bits_reg  <= 4'hA;
      tx_cnt_reg   <= bit_cyc;
    end else if (!tx_idle) begin
      if (tx_cnt_reg == 32'h1) begin
        tx_shift_reg <= {1'b1, tx_shift_reg[9:1]};
        tx_bits_reg  <= tx_bits_reg - 4'h1;
        tx_cnt_reg   <= bit_cyc;
      end else begin
        tx_cnt_reg <= tx_cnt_reg - 32'h1;
      end
    end
  end
  assign txd = tx_shift_reg[0];

  logic        rx_s1_reg, rx_s2_reg;
  logic [7:0]  rx_sh_reg;
  logic [3:0]  rx_bits_reg;
  logic [31:0] rx_cnt_reg;
  logic        rx_stb_reg;
  logic [7:0]  rx_byte_reg;

  // Two-stage synchroniser, then bit sampler at mid-bit
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_s1_reg   <= 1'b1;
      rx_s2_reg   <= 1'b1;
      rx_sh_reg   <= 8'h00;
      rx_bits_reg <= 4'h0;
      rx_cnt_reg  <= 32'h0;
      rx_stb_reg  <= 1'b0;
      rx_byte_reg <= 8'h00;
    end else begin
      rx_s1_reg  <= rxd;
      rx_s2_reg  <= rx_s1_reg;
      rx_stb_reg <= 1'b0;
      if (rx_bits_reg == 4'h0) begin
        if (!rx_s2_reg) begin
          rx_bits_reg <= 4'hA;
          rx_cnt_reg  <= bit_cyc >> 1;
        end
      end else if (rx_cnt_reg == 32'h0) begin
        rx_cnt_reg  <= bit_cyc - 32'h1; // Count to zero spans one bit
        rx_bits_reg <= rx_bits_reg - 4'h1;
        if (rx_bits_reg == 4'hA && rx_s2_reg) begin
          rx_bits_reg <= 4'h0; // False start
        end else if (rx_bits_reg == 4'h1) begin
          rx_stb_reg  <= rx_s2_reg; // Stop bit must be high
          rx_byte_reg <= rx_sh_reg;
        end else if (rx_bits_reg != 4'hA) begin
          rx_sh_reg <= {rx_s2_reg, rx_sh_reg[7:1]};
        end
      end else begin
        rx_cnt_reg <= rx_cnt_reg - 32'h1;
      end
    end
  end

  // ------------------------------------------------------------
  // Link protocol engine
  // ------------------------------------------------------------
  logic [7:0]  idx_reg, sum_reg, rx_n_reg, ans_reg;
  logic [3:0]  retry_reg;
  logic [31:0] tick_reg;
  logic [7:0]  units_reg;
  logic        tx_pend_reg;

  wire [7:0] blk_last  = hdr_n_reg + 8'(BLOCK_EXTRA); // Index of checksum byte
  wire [7:0] blk_byte  = (idx_reg == 8'h00) ? hdr_n_reg :
                         (idx_reg == 8'h01) ? {4'h0, hdr_axis_reg} :
                         (idx_reg == 8'h02) ? {hdr_cmd_reg, hdr_mode_reg} :
                         (idx_reg == blk_last) ? 8'(-sum_reg) : txbuf[8'(idx_reg - 8'h03)];
  wire       unit_tick = tick_reg == 32'h1;
  wire       char_exp  = unit_tick && units_reg == 8'h01;
  wire       fail_out  = retry_reg >= cfg_reg.retry_limit;
  wire       rx_req    = rx_stb_reg && rx_byte_reg == CODE_REQ;
  // Unit length to reload while a timeout runs
  wire [31:0] tick_len = (state_reg == ST_RECV_BLK) ? 32'(CHAR_TICK) : 32'(PROTO_TICK);

  assign tx_go   = (state_reg == ST_SEND_REQ) || (state_reg == ST_SEND_RDY) ||
                   (state_reg == ST_SEND_ANS) || (state_reg == ST_SEND_BLK);
  assign tx_byte = (state_reg == ST_SEND_REQ) ? CODE_REQ :
                   (state_reg == ST_SEND_RDY) ? CODE_RDY :
                   (state_reg == ST_SEND_ANS) ? ans_reg : blk_byte;

  // Protocol sequencer with unit-based timeout counter
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      idx_reg <= 8'h00; sum_reg <= 8'h00; rx_n_reg <= 8'h00; ans_reg <= CODE_ACK;
      retry_reg <= 4'h0; tick_reg <= 32'h0; units_reg <= 8'h00; tx_pend_reg <= 1'b0;
      busy_reg <= 1'b0; done_reg <= 1'b0; err_reg <= 1'b0; rx_new_reg <= 1'b0;
      rx_len_reg <= 8'h00;
    end else begin
      tick_reg <= unit_tick ? tick_reg : tick_reg - 32'h1;
      if (unit_tick && units_reg != 8'h00) begin
        units_reg <= units_reg - 8'h01;
        tick_reg  <= tick_len;
      end
      if (sw_req.rd && sel_ctrl) begin
        done_reg <= 1'b0; err_reg <= 1'b0; rx_new_reg <= 1'b0;
      end
      case (state_reg)
        ST_IDLE: begin
          if (rx_req) begin
            state_reg <= ST_SEND_RDY;
          end else if (go_wr) begin
            busy_reg <= 1'b1; retry_reg <= 4'h0;
            state_reg <= ST_SEND_REQ;
          end
        end
        ST_SEND_REQ: if (tx_idle) begin
          state_reg <= ST_WAIT_RDY;
          tick_reg <= 32'(PROTO_TICK); units_reg <= cfg_reg.protocol_time_limit;
        end
        ST_WAIT_RDY: begin
          if (rx_req && !cfg_reg.master) begin
            state_reg <= ST_SEND_RDY;
          end else if (rx_stb_reg && rx_byte_reg == CODE_RDY) begin
            state_reg <= ST_SEND_BLK; idx_reg <= 8'h00; sum_reg <= 8'h00;
          end else if (char_exp) begin
            if (fail_out) begin
              state_reg <= ST_IDLE; busy_reg <= 1'b0; err_reg <= 1'b1;
            end else begin
              retry_reg <= retry_reg + 4'h1; state_reg <= ST_SEND_REQ;
            end
          end
        end
        ST_SEND_BLK: if (tx_idle) begin
          sum_reg <= sum_reg + blk_byte;
          idx_reg <= idx_reg + 8'h01;
          if (idx_reg == blk_last) begin
            state_reg <= ST_WAIT_ACK;
            tick_reg <= 32'(PROTO_TICK); units_reg <= cfg_reg.protocol_time_limit;
          end
        end
        ST_WAIT_ACK: begin
          if (rx_stb_reg && rx_byte_reg == CODE_ACK) begin
            state_reg <= ST_IDLE; busy_reg <= 1'b0; done_reg <= 1'b1; retry_reg <= 4'h0;
          end else if (rx_stb_reg || char_exp) begin
            if (fail_out) begin
              state_reg <= ST_IDLE; busy_reg <= 1'b0; err_reg <= 1'b1;
            end else begin
              retry_reg <= retry_reg + 4'h1; state_reg <= ST_SEND_REQ;
            end
          end
        end
        ST_SEND_RDY: if (tx_idle) begin
          tx_pend_reg <= busy_reg;
          state_reg <= ST_WAIT_FIRST; idx_reg <= 8'h00; sum_reg <= 8'h00;
          tick_reg <= 32'(PROTO_TICK); units_reg <= cfg_reg.protocol_time_limit;
        end
        ST_WAIT_FIRST, ST_RECV_BLK: begin
          if (rx_stb_reg) begin
            sum_reg <= sum_reg + rx_byte_reg;
            idx_reg <= idx_reg + 8'h01;
            tick_reg <= 32'(CHAR_TICK); units_reg <= cfg_reg.char_timeout;
            state_reg <= ST_RECV_BLK;
            if (state_reg == ST_WAIT_FIRST) begin
              rx_n_reg <= rx_byte_reg;
            end
            if (state_reg == ST_RECV_BLK && idx_reg == rx_n_reg + 8'(BLOCK_EXTRA)) begin
              ans_reg <= (8'(sum_reg + rx_byte_reg) == 8'h00) ? CODE_ACK : CODE_NAK;
              rx_new_reg <= (8'(sum_reg + rx_byte_reg) == 8'h00);
              rx_len_reg <= idx_reg + 8'h01;
              state_reg <= ST_SEND_ANS;
            end
          end else if (char_exp) begin
            ans_reg <= CODE_NAK; state_reg <= ST_SEND_ANS;
          end
        end
        ST_SEND_ANS: if (tx_idle) begin
          state_reg <= tx_pend_reg ? ST_SEND_REQ : ST_IDLE; // Resume yielded block
          tx_pend_reg <= 1'b0;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Received-block store, kept out of the reset process
  always_ff @(posedge core_clk) begin
    if (rx_stb_reg && (state_reg == ST_WAIT_FIRST || state_reg == ST_RECV_BLK)) begin
      rxbuf[idx_reg] <= rx_byte_reg;
    end
  end

  // Received-block readout pointer
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_rd_reg <= 8'h00;
    end else if (state_reg == ST_SEND_ANS) begin
      rx_rd_reg <= 8'h00;
    end else if (sw_req.rd && sel_rxdata) begin
      rx_rd_reg <= rx_rd_reg + 8'h01;
    end
  end

  // Read data, one cycle after the strobe
  wire [31:0] rd_mux = sel_ctrl   ? {27'h0, rx_new_reg, err_reg, done_reg, busy_reg, 1'b0} :
                       sel_config ? {24'h0, cfg_reg.retry_limit, 1'b0, cfg_reg.master, cfg_reg.baud_sel} :
                       sel_times  ? {16'h0, cfg_reg.protocol_time_limit, cfg_reg.char_timeout} :
                       sel_header ? {12'h0, hdr_mode_reg, hdr_cmd_reg, hdr_axis_reg, hdr_n_reg} :
                       sel_rxdata ? {24'h0, rxbuf[rx_rd_reg]} :
                       sel_rxinfo ? {20'h0, retry_reg, rx_len_reg} : 32'h0;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sw_rdata_reg <= 32'h0;
    end else begin
      sw_rdata_reg <= sw_req.rd ? rd_mux : 32'h0;
    end
  end
  assign sw_rdata = sw_rdata_reg;
endmodule : link_host
`default_nettype wire

// ===== sim/link_host_sva.sv
// Checker for the link host software port and serial output
`timescale 1ns/1ps
`default_nettype none
module link_host_sva
  import link_host_pkg::*;
#(
  parameter int CLK_FREQ   = CLK_HZ,
  parameter int CHAR_TICK  = CHAR_TICK_CYC,
  parameter int PROTO_TICK = PROTO_TICK_CYC
) (
  input wire logic                      core_clk,
  input wire logic                      rst,
  input wire link_host_pkg::sw_req_type sw_req,
  input wire logic [31:0]               sw_rdata,
  input wire logic                      rxd,
  input wire logic                      txd
);
  localparam int BIT = CLK_FREQ / BAUD_2400;
  int          low_cnt;   // Length of the current low run on txd
  logic [15:0] times_reg; // Shadow of the timing register
  // Measure low runs and follow timing writes
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      low_cnt   <= 0;
      times_reg <= {PROTO_TL_DEFAULT, CHAR_TO_DEFAULT};
    end else begin
      low_cnt <= txd ? 0 : low_cnt + 1;
      if (sw_req.wr && sw_req.addr == REG_TIMES) times_reg <= sw_req.wdata[15:0];
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  rdata_idle_a: assert property (!$past(sw_req.rd) |-> sw_rdata == 32'h0)
    else $error("read data not zero outside a read reply");
  unmapped_zero_a: assert property ($past(sw_req.rd) && $past(sw_req.addr) > REG_RXINFO |-> sw_rdata == 32'h0)
    else $error("unmapped address did not read zero");
  timing_read_a: assert property ($past(sw_req.rd) && $past(sw_req.addr) == REG_TIMES
    |-> sw_rdata[15:0] == $past(times_reg)) else $error("timing register read back wrong");
  config_range_a: assert property ($past(sw_req.rd) && $past(sw_req.addr) == REG_CONFIG
    |-> sw_rdata[7:4] inside {[4'h1:4'h8]} && sw_rdata[1:0] != 2'h3) else $error("setting out of range");
  retry_count_a: assert property ($past(sw_req.rd) && $past(sw_req.addr) == REG_RXINFO
    |-> sw_rdata[11:8] <= 4'h8) else $error("retry count beyond eight");
  reset_idle_a: assert property ($fell(rst) |-> (txd && sw_rdata == 32'h0) ##1 txd)
    else $error("line not idle after reset");
  bit_width_a: assert property ($rose(txd) |-> (low_cnt % BIT) <= 2 || (low_cnt % BIT) >= BIT - 2)
    else $error("low run not a whole number of bits");
  low_run_a: assert property (low_cnt <= 9 * BIT + 2)
    else $error("line low longer than one character");
endmodule : link_host_sva
bind link_host link_host_sva #(.CLK_FREQ(CLK_FREQ), .CHAR_TICK(CHAR_TICK), .PROTO_TICK(PROTO_TICK)) i_sva (
  .core_clk(core_clk), .rst(rst), .sw_req(sw_req), .sw_rdata(sw_rdata), .rxd(rxd), .txd(txd));
`default_nettype wire

// ===== sim/servo_dev_model.sv
// Behavioural servo driver serial port facing the link host
`timescale 1ns/1ps
`default_nettype none
module servo_dev_model
  import link_host_pkg::*;
#(
  parameter int BIT_CYC = BIT_CYC_2400
) (
  input  wire logic core_clk,
  input  wire logic txd,
  output var  logic rxd
);
  logic [7:0] blk [256]; // Last block taken from the host
  int         blk_len;
  logic [7:0] rxq [$];   // Characters heard on the host line
  // Line rests at mark level
  initial rxd = 1'b1;
  // Gather every 8N1 character the host sends, sampled at bit centres
  always begin : host_rx
    logic [7:0] b;
    @(negedge txd);
    repeat (BIT_CYC / 2) @(posedge core_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(posedge core_clk);
      b[i] = txd;
    end
    repeat (BIT_CYC) @(posedge core_clk);
    rxq.push_back(b);
  end
  task automatic get_byte(output logic [7:0] b);
    wait (rxq.size() > 0);
    b = rxq.pop_front();
  endtask : get_byte
  // Send one character, start bit first and LSB first
  task automatic put_byte(input logic [7:0] b);
    logic [9:0] frame;
    frame = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd <= frame[i];
      repeat (BIT_CYC) @(posedge core_clk);
    end
  endtask : put_byte
  // Accept a block from the host and answer with the given code
  task automatic take_block(input logic [7:0] answer, output logic [7:0] first);
    get_byte(first);
    put_byte(CODE_RDY);
    get_byte(blk[0]);
    blk_len = int'(blk[0]) + 4;
    for (int i = 1; i < blk_len; i++) get_byte(blk[i]);
    put_byte(answer);
  endtask : take_block
  // Offer a block to the host and report its ready and answer codes
  task automatic give_block(input logic [7:0] bytes [4], output logic [7:0] rdy, output logic [7:0] ans);
    put_byte(CODE_REQ);
    get_byte(rdy);
    foreach (bytes[i]) put_byte(bytes[i]);
    get_byte(ans);
  endtask : give_block
endmodule : servo_dev_model
`default_nettype wire

// ===== sim/link_host_tb.sv
// Self-checking bench for the link host controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin err_total++; \
  $display("[ERR] t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end
module link_host_tb;
  import link_host_pkg::*;
  logic        core_clk;
  logic        rst;
  sw_req_type  sw_req;
  logic [31:0] sw_rdata;
  logic        rxd;
  logic        txd;
  int          err_total;
  int          checks;
  logic [31:0] d;
  logic [7:0]  b0;
  logic [7:0]  b1;
  time         t0;
  int          gap;
  localparam logic [7:0] TX_BLK [5] = '{8'h01, 8'h03, 8'h81, 8'h2A, 8'h51};
  localparam int SIM_CLK = 38400; // 16 cycles per bit at 2400 bps
  // Short bits and time units keep the run short; timeouts stay above a character time
  link_host #(.CLK_FREQ(SIM_CLK), .CHAR_TICK(100), .PROTO_TICK(200)) i_dut (
    .core_clk(core_clk), .rst(rst), .sw_req(sw_req), .sw_rdata(sw_rdata), .rxd(rxd), .txd(txd));
  servo_dev_model #(.BIT_CYC(SIM_CLK / BAUD_2400)) i_dev (.core_clk(core_clk), .txd(txd), .rxd(rxd));
  always #4 core_clk = ~core_clk;
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    sw_req <= '{a, v, 1'b1, 1'b0};
    @(posedge core_clk);
    sw_req.wr <= 1'b0;
    @(posedge core_clk);
  endtask : wr
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    sw_req <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge core_clk);
    sw_req.rd <= 1'b0;
    #1 v = sw_rdata;
    @(posedge core_clk);
  endtask : rd
  task automatic wait_flag(output logic [31:0] v);
    for (int n = 0; n < 400; n++) begin
      rd(REG_CTRL, v);
      if (v[3:2] !== 2'b00) break;
      repeat (100) @(posedge core_clk);
    end
  endtask : wait_flag
  // Let the device take one block and check every byte of it
  task automatic take_check(input logic [7:0] answer);
    i_dev.take_block(answer, b0);
    `CHK(b0, CODE_REQ)
    `CHK(i_dev.blk_len, 5)
    for (int i = 0; i < 5; i++) `CHK(i_dev.blk[i], TX_BLK[i])
  endtask : take_check
  task automatic report_and_stop();
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : report_and_stop
  // Watchdog at about three times the expected run of some 20,000 cycles
  initial begin
    #480000;
    err_total++;
    report_and_stop();
  end
  initial begin
    core_clk = 1'b0;
    rst = 1'b1;
    sw_req = '0;
    err_total = 0;
    checks = 0;
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    rd(REG_TIMES, d);
    `CHK(d, 32'h0000_0A05)
    rd(REG_CONFIG, d);
    `CHK(d & 32'hF7, 32'h10)
    rd(4'hF, d);
    `CHK(d, 32'h0)
    wr(REG_TIMES, 32'h0B06);
    rd(REG_TIMES, d);
    `CHK(d, 32'h0000_0B06)
    wr(REG_CONFIG, 32'h12);
    rd(REG_CONFIG, d);
    `CHK(d & 32'hF7, 32'h12)
    // Good transfer, then one that is refused twice
    for (int k = 0; k < 2; k++) begin
      wr(REG_HEADER, 32'h0001_8301);
      wr(REG_TXDATA, 32'h2A);
      wr(REG_CTRL, 32'h1);
      take_check(k ? CODE_NAK : CODE_ACK);
      if (k == 1) take_check(CODE_NAK);
      wait_flag(d);
      `CHK(d, k ? 32'h8 : 32'h4)
      rd(REG_RXINFO, d);
      if (k == 0) `CHK(d[11:8], 4'h0)
    end
    // Blocks offered by the device: good sum, then sum off by one
    for (int k = 0; k < 2; k++) begin
      i_dev.give_block('{8'h00, 8'h01, 8'h21, 8'hDE + 8'(k)}, b0, b1);
      `CHK(b0, CODE_RDY)
      `CHK(b1, (k == 0) ? CODE_ACK : CODE_NAK)
      if (k == 0) begin
        rd(REG_CTRL, d);
        `CHK(d[4], 1'b1)
        rd(REG_RXDATA, d);
        `CHK(d[7:0], 8'h00)
      end
    end
    // Device request meets a pending slave request: yield, receive, then resume
    wr(REG_HEADER, 32'h0001_8301);
    wr(REG_TXDATA, 32'h2A);
    wr(REG_CTRL, 32'h1);
    i_dev.get_byte(b0);
    `CHK(b0, CODE_REQ)
    i_dev.give_block('{8'h00, 8'h01, 8'h21, 8'hDE}, b0, b1);
    `CHK(b0, CODE_RDY)
    `CHK(b1, CODE_ACK)
    take_check(CODE_ACK);
    wait_flag(d);
    `CHK(d, 32'h14)
    // Silent device: request resent after the protocol limit, then error
    wr(REG_CTRL, 32'h1);
    i_dev.get_byte(b0);
    t0 = $time;
    i_dev.get_byte(b1);
    gap = int'(($time - t0) / 8);
    `CHK({b0, b1}, {CODE_REQ, CODE_REQ})
    `CHK(gap inside {[2190:2215]}, 1'b1)
    wait_flag(d);
    `CHK(d, 32'h8)
    // Device stalls after the ready code, then inside a block
    for (int k = 0; k < 2; k++) begin
      i_dev.put_byte(CODE_REQ);
      i_dev.get_byte(b0);
      `CHK(b0, CODE_RDY)
      if (k == 1) i_dev.put_byte(8'h01);
      t0 = $time;
      i_dev.get_byte(b1);
      gap = int'(($time - t0) / 8);
      `CHK(b1, CODE_NAK)
      if (k == 0) `CHK(gap inside {[2150:2250]}, 1'b1)
      else `CHK(gap inside {[700:800]}, 1'b1)
    end
    report_and_stop();
  end
endmodule : link_host_tb
`default_nettype wire
